// file: design/pciinv_engine.sv
`timescale 1ns/10ps
`default_nettype none
`include "pciinv_params.svh"

module pciinv_engine (
    input wire logic CLK_I,                     // system clock, 100 MHz
    input wire logic RESET_N_I,                 // async reset, active low
    input wire logic [7:0] REG_ADDR_I,          // user region byte offset
    input wire logic REG_WRITE_I,               // register write strobe
    input wire logic [31:0] REG_WDATA_I,        // register write data
    input wire logic REG_READ_I,                // register read strobe
    output logic [31:0] REG_RDATA_O,            // register read data
    output logic REG_RDVALID_O,                 // read data valid pulse
    input wire logic [31:0] DMA_WR_ADDR_I,      // dma word address in
    input wire logic [127:0] DMA_WR_DATA_I,     // dma data in
    input wire logic DMA_WR_I,                  // dma write strobe
    output logic DMA_WR_READY_O,                // buffer can take a write
    input wire logic [31:0] DMA_RD_ADDR_I,      // dma word address out
    input wire logic DMA_RD_I,                  // dma read strobe
    output logic [127:0] DMA_RD_DATA_O,         // dma data out
    output logic DMA_RD_VALID_O,                // dma data valid pulse
    output logic DMA_FIFO_OR_MEMORY_SELECT_O,   // low: memory-mapped mode
    output logic [15:0] VENDOR_ID_O,            // vendor identifier
    output logic [15:0] DEVICE_ID_O,            // device identifier
    output logic BUSY_O                         // pass under way
);
    localparam int AW = `PCIINV_ADDR_BITS;
    localparam int DW = `PCIINV_WORD_BITS;

    // ****************************************
    // frame buffer
    // ****************************************
    logic [DW-1:0] frame [`PCIINV_FB_WORDS];
    logic [DW-1:0] ram_q;
    logic ram_rd_en;
    logic [AW-1:0] ram_rd_addr;
    logic ram_wr_en;
    logic [AW-1:0] ram_wr_addr;
    logic [DW-1:0] ram_wr_data;

    always_ff @(posedge CLK_I) begin
        if (ram_wr_en) begin
            frame[ram_wr_addr] <= ram_wr_data;
        end
        if (ram_rd_en) begin
            ram_q <= frame[ram_rd_addr];
        end
    end

    // ****************************************
    // download path through the fifo
    // ****************************************
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [AW+DW-1:0] fifo_out_data;
    logic fifo_in_ready;
    logic wr_in_range;

    // addresses past the image are dropped, not wrapped
    assign wr_in_range = (DMA_WR_ADDR_I <= {18'h0, `PCIINV_FB_LAST});

    pciinv_fifo #(
        .WIDTH(AW + DW),
        .DEPTH(`PCIINV_FIFO_DEPTH),
        .AW(`PCIINV_FIFO_AW)
    ) u_fifo (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .in_valid_i(DMA_WR_I && wr_in_range),
        .in_ready_o(fifo_in_ready),
        .in_data_i({DMA_WR_ADDR_I[AW-1:0], DMA_WR_DATA_I}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // ****************************************
    // inversion engine and register state
    // ****************************************
    pciinv_pkg::pciinv_state_e state;
    pciinv_pkg::pciinv_state_e next_state;
    logic [AW-1:0] idx;
    logic [AW-1:0] next_idx;
    logic start_pend;
    logic next_start_pend;
    logic rd_pend;
    logic next_rd_pend;
    logic [AW-1:0] rd_addr;
    logic [AW-1:0] next_rd_addr;
    logic rd_hit;
    logic next_rd_hit;
    logic rd_serve;
    logic reg_sel;
    logic [31:0] status;
    logic [31:0] next_reg_rdata;
    logic next_reg_rdvalid;
    logic next_dma_rd_valid;

    assign reg_sel = (REG_ADDR_I == `PCIINV_CMD_STATUS_OFFSET);
    // engine claims the write port only in its write state
    assign fifo_out_ready = (state != pciinv_pkg::PCIINV_WRITE);
    // a read the core asked for waits while the engine owns the read port
    assign rd_serve = rd_pend && (state != pciinv_pkg::PCIINV_READ);

    always_comb begin
        // progress: busy flag plus the word index being worked on
        status = `PCIINV_CMD_STATUS_RESET;
        if (state != pciinv_pkg::PCIINV_IDLE || start_pend) begin
            status[`PCIINV_STATUS_BUSY_BIT] = 1'b1;
            status[AW-1:0] = idx;
        end
    end

    always_comb begin
        next_state = state;
        next_idx = idx;
        next_start_pend = start_pend;
        ram_rd_en = 1'b0;
        ram_rd_addr = idx;
        ram_wr_en = 1'b0;
        ram_wr_addr = fifo_out_data[AW+DW-1:DW];
        ram_wr_data = fifo_out_data[DW-1:0];
        unique case (state)
            pciinv_pkg::PCIINV_IDLE: begin
                // wait until every queued download word has landed
                if (start_pend && !fifo_out_valid) begin
                    next_start_pend = 1'b0;
                    next_idx = `PCIINV_FB_BASE;
                    next_state = pciinv_pkg::PCIINV_READ;
                end
            end
            pciinv_pkg::PCIINV_READ: begin
                ram_rd_en = 1'b1;
                next_state = pciinv_pkg::PCIINV_WRITE;
            end
            pciinv_pkg::PCIINV_WRITE: begin
                ram_wr_en = 1'b1;
                ram_wr_addr = idx;
                ram_wr_data = ~ram_q;
                if (idx == `PCIINV_FB_LAST) begin
                    next_state = pciinv_pkg::PCIINV_IDLE;
                end else begin
                    next_idx = idx + 1'b1;
                    next_state = pciinv_pkg::PCIINV_READ;
                end
            end
        endcase
        if (state != pciinv_pkg::PCIINV_WRITE && fifo_out_valid) begin
            ram_wr_en = 1'b1;
        end
        if (rd_serve) begin
            ram_rd_en = 1'b1;
            ram_rd_addr = rd_addr;
        end
        // a write while busy restarts the pass from word zero
        if (REG_WRITE_I && reg_sel) begin
            next_start_pend = 1'b1;
            next_state = pciinv_pkg::PCIINV_IDLE;
        end
    end

    always_comb begin
        next_rd_pend = rd_pend && !rd_serve;
        next_rd_addr = rd_addr;
        next_rd_hit = rd_hit;
        if (DMA_RD_I) begin
            next_rd_pend = 1'b1;
            next_rd_addr = DMA_RD_ADDR_I[AW-1:0];
            next_rd_hit = (DMA_RD_ADDR_I <= {18'h0, `PCIINV_FB_LAST});
        end
        next_dma_rd_valid = rd_serve;
        next_reg_rdvalid = REG_READ_I;
        next_reg_rdata = REG_READ_I && reg_sel ? status : 32'h0;
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state <= pciinv_pkg::PCIINV_IDLE;
            idx <= `PCIINV_FB_BASE;
            start_pend <= 1'b0;
            rd_pend <= 1'b0;
            rd_addr <= `PCIINV_FB_BASE;
            rd_hit <= 1'b0;
            REG_RDATA_O <= 32'h0000_0000;
            REG_RDVALID_O <= 1'b0;
            DMA_RD_VALID_O <= 1'b0;
            DMA_WR_READY_O <= 1'b0;
            BUSY_O <= 1'b0;
            DMA_FIFO_OR_MEMORY_SELECT_O <= 1'b0;
            VENDOR_ID_O <= 16'h0000;
            DEVICE_ID_O <= 16'h0000;
        end else begin
            state <= next_state;
            idx <= next_idx;
            start_pend <= next_start_pend;
            rd_pend <= next_rd_pend;
            rd_addr <= next_rd_addr;
            rd_hit <= next_rd_hit;
            REG_RDATA_O <= next_reg_rdata;
            REG_RDVALID_O <= next_reg_rdvalid;
            DMA_RD_VALID_O <= next_dma_rd_valid;
            // registered ready: drops for the cycle after each in-range write to cover the lag
            DMA_WR_READY_O <= fifo_in_ready && !(DMA_WR_I && wr_in_range);
            BUSY_O <= (next_state != pciinv_pkg::PCIINV_IDLE) ||
                      next_start_pend;
            DMA_FIFO_OR_MEMORY_SELECT_O <= 1'b0;
            VENDOR_ID_O <= `PCIINV_VENDOR_ID;
            DEVICE_ID_O <= `PCIINV_DEVICE_ID;
        end
    end

    // out-of-range reads answer zero instead of aliasing into the image
    // registered here so the upload word leaves straight from a flop
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            DMA_RD_DATA_O <= {DW{1'b0}};
        end else if (rd_serve) begin
            DMA_RD_DATA_O <= rd_hit ? frame[rd_addr] : {DW{1'b0}};
        end
    end
endmodule
`default_nettype wire

// file: design/pciinv_params.svh
`ifndef PCIINV_PARAMS_SVH
`define PCIINV_PARAMS_SVH

// ****************************************
// frame buffer geometry
// ****************************************
`define PCIINV_IMG_WIDTH 320
`define PCIINV_IMG_HEIGHT 240
`define PCIINV_BYTES_PER_PIXEL 3
`define PCIINV_WORD_BITS 128
`define PCIINV_WORD_BYTES 16
`define PCIINV_FB_BASE 14'h0000
// 320*240*3 bytes in 16-byte words
`define PCIINV_FB_WORDS 14400
`define PCIINV_FB_LAST 14'h383F
`define PCIINV_ADDR_BITS 14

// ****************************************
// registers of the user region
// ****************************************
`define PCIINV_REG_ADDR_BITS 8
`define PCIINV_CMD_STATUS_OFFSET 8'h10
`define PCIINV_CMD_STATUS_RESET 32'h0000_0000
`define PCIINV_STATUS_BUSY_BIT 31

// ****************************************
// data path buffer
// ****************************************
`define PCIINV_FIFO_DEPTH 32
`define PCIINV_FIFO_AW 5

// ****************************************
// identity, values arbitrary
// ****************************************
`define PCIINV_VENDOR_ID 16'h5A5A
`define PCIINV_DEVICE_ID 16'hA5A5

`endif

// file: design/pciinv_pkg.sv
package pciinv_pkg;
    // gray codes along idle -> read -> write
    typedef enum logic [1:0] {
        PCIINV_IDLE = 2'h0,
        PCIINV_READ = 2'h1,
        PCIINV_WRITE = 2'h3
    } pciinv_state_e;
endpackage

// file: design/pciinv_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module pciinv_fifo #(
    parameter int WIDTH = 142,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk_i,               // system clock
    input wire logic reset_n_i,           // async reset, active low
    input wire logic in_valid_i,          // producer offers a word
    output logic in_ready_o,              // room for a word
    input wire logic [WIDTH-1:0] in_data_i, // word offered
    output logic out_valid_o,             // a word is held
    input wire logic out_ready_i,         // consumer takes the word
    output logic [WIDTH-1:0] out_data_o   // oldest word
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage needs no reset; only words below count are ever read
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// file: bench/pciinv_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "pciinv_params.svh"
module pciinv_props (
    input wire logic CLK_I, // clock
    input wire logic RESET_N_I, // reset
    input wire logic [7:0] REG_ADDR_I, // offset
    input wire logic REG_WRITE_I, // write
    input wire logic REG_READ_I, // read
    input wire logic [31:0] REG_RDATA_O, // read data
    input wire logic REG_RDVALID_O, // read valid
    input wire logic DMA_RD_I, // upload request
    input wire logic DMA_RD_VALID_O, // upload valid
    input wire logic DMA_FIFO_OR_MEMORY_SELECT_O, // mode
    input wire logic BUSY_O // pass running
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // ********
    // busy cycles since the last start
    // ********
    logic [15:0] run_cnt;
    logic [15:0] next_run_cnt;
    wire logic hit = REG_ADDR_I == `PCIINV_CMD_STATUS_OFFSET;
    always_comb begin
        next_run_cnt = run_cnt + {15'h0000, BUSY_O};
        if (REG_WRITE_I && hit) next_run_cnt = 16'h0000;
    end
    // restart clears it, so only a full final pass is measured
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) run_cnt <= 16'h0000;
        else run_cnt <= next_run_cnt;
    end
    sequence s_rd_busy; REG_READ_I && hit && BUSY_O ##1 BUSY_O; endsequence
    sequence s_rd_idle; REG_READ_I && hit && !BUSY_O ##1 !BUSY_O; endsequence
    property p_rd_ans; REG_READ_I |=> REG_RDVALID_O; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read lost");
    property p_start; REG_WRITE_I && hit |=> BUSY_O; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_other; REG_READ_I && !hit |=> REG_RDATA_O == 32'h0; endproperty
    a_other: assert property (p_other) else $error("bad offset");
    property p_busy; s_rd_busy |-> REG_RDATA_O[31]; endproperty
    a_busy: assert property (p_busy) else $error("busy unseen");
    property p_idle; s_rd_idle |-> REG_RDATA_O == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("idle nonzero");
    property p_upl; DMA_RD_I |-> ##[1:3] DMA_RD_VALID_O; endproperty
    a_upl: assert property (p_upl) else $error("upload lost");
    property p_mode; DMA_FIFO_OR_MEMORY_SELECT_O == 1'b0; endproperty
    a_mode: assert property (p_mode) else $error("fifo mode");
    property p_len; $fell(BUSY_O) |-> run_cnt >= 16'h7000; endproperty
    a_len: assert property (p_len) else $error("pass short");
endmodule
bind pciinv_engine pciinv_props u_props (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WRITE_I(REG_WRITE_I), .REG_READ_I(REG_READ_I),
    .REG_RDATA_O(REG_RDATA_O), .REG_RDVALID_O(REG_RDVALID_O),
    .DMA_RD_I(DMA_RD_I), .DMA_RD_VALID_O(DMA_RD_VALID_O), .BUSY_O(BUSY_O),
    .DMA_FIFO_OR_MEMORY_SELECT_O(DMA_FIFO_OR_MEMORY_SELECT_O)
);
`default_nettype wire

// file: bench/pciinv_dma_model.sv
`timescale 1ns/10ps
`default_nettype none
module pciinv_dma_model (
    input wire logic clk_i, // clock
    input wire logic ready_i, // buffer room
    output logic [31:0] wa_o, // download address
    output logic [127:0] wd_o, // download word
    output logic wr_o, // download strobe
    output logic [31:0] ra_o, // upload address
    output logic rd_o // upload strobe
);
    // ********
    // core dma channel, memory-mapped mode
    // ********
    initial begin
        {wr_o, rd_o, wa_o, wd_o, ra_o} = '0;
    end
    // one address per 128-bit word; waits at most 99 cycles for buffer room
    task automatic put(logic [31:0] a, logic [127:0] d);
        for (int n = 0; n < 99 && !ready_i; n++) begin
            rest();
            @(posedge clk_i);
        end
        wr_o <= 1'b1;
        wa_o <= a;
        wd_o <= d;
        @(posedge clk_i);
    endtask
    // released lines toggle so stale values never look valid
    task automatic rest();
        wr_o <= 1'b0;
        wa_o <= ~wa_o;
        wd_o <= ~wd_o;
    endtask
    task automatic get(logic [31:0] a);
        rd_o <= 1'b1;
        ra_o <= a;
        @(posedge clk_i);
        rd_o <= 1'b0;
        ra_o <= ~a;
        repeat (2) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// file: bench/pciinv_engine_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pciinv_params.svh"
module pciinv_engine_tb;
    logic clk, rst_n, rwr, rrd, rdv, dwr, drd, drv, rdy, sel, busy, full;
    logic [7:0] radr;
    logic [31:0] wdat, rdat, dwa, dra, seed;
    logic [127:0] dwd, drdat;
    logic [15:0] vid, did;
    logic [63:0] reg_q[$];
    logic [127:0] dma_q[$];
    logic [127:0] img[80];
    logic [63:0] note;
    int bad_count, n_tests, i;
    localparam logic [63:0] busy_note = 64'h8000_0000_8000_0000;
    localparam logic [63:0] idle_note = 64'hFFFF_FFFF_0000_0000;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    pciinv_engine dut_u (
        .CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(radr),
        .REG_WRITE_I(rwr), .REG_WDATA_I(wdat), .REG_READ_I(rrd),
        .REG_RDATA_O(rdat), .REG_RDVALID_O(rdv), .DMA_WR_ADDR_I(dwa),
        .DMA_WR_DATA_I(dwd), .DMA_WR_I(dwr), .DMA_WR_READY_O(rdy),
        .DMA_RD_ADDR_I(dra), .DMA_RD_I(drd), .DMA_RD_DATA_O(drdat),
        .DMA_RD_VALID_O(drv), .DMA_FIFO_OR_MEMORY_SELECT_O(sel),
        .VENDOR_ID_O(vid), .DEVICE_ID_O(did), .BUSY_O(busy)
    );
    pciinv_dma_model u_dma (
        .clk_i(clk), .ready_i(rdy), .wa_o(dwa), .wd_o(dwd), .wr_o(dwr),
        .ra_o(dra), .rd_o(drd)
    );
    // ********
    // helpers
    // ********
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic check(string nm, logic [127:0] s, logic [127:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // n holds {mask, expected} for a read; data written is random
    task automatic reg_op(logic w, logic [7:0] a, logic [63:0] n);
        seed = xs(seed);
        radr <= a;
        rwr <= w;
        rrd <= !w;
        wdat <= seed;
        if (!w) reg_q.push_back(n);
        @(posedge clk);
        rwr <= 1'b0;
        rrd <= 1'b0;
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (rst_n && rdy === 1'b0) full = 1'b1;
        if (rdv === 1'b1 && reg_q.size() > 0) begin
            note = reg_q.pop_front();
            check("reg", 128'(rdat & note[63:32]), 128'(note[31:0]));
        end
        if (drv === 1'b1 && dma_q.size() > 0) begin
            check("upload", drdat, dma_q.pop_front());
        end
    end
    initial begin
        {rst_n, rwr, rrd, radr, wdat, full} = '0;
        bad_count = 0;
        n_tests = 0;
        seed = 32'h0000_36FD;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("vendor", 128'(vid), 128'(`PCIINV_VENDOR_ID));
        check("device", 128'(did), 128'(`PCIINV_DEVICE_ID));
        check("mode", 128'(sel), 128'h0);
        reg_op(1'b1, `PCIINV_CMD_STATUS_OFFSET, 64'h0);
        // let the first pass run past the words about to be loaded
        repeat (200) @(posedge clk);
        full = 1'b0;
        for (i = 0; i < 80; i++) begin
            seed = xs(seed);
            img[i] = {seed, ~seed, seed ^ 32'h0F0F_0F0F, 32'(i)};
            u_dma.put(32'(i), img[i]);
        end
        // a word beyond the image must be dropped, not wrap onto word 0
        u_dma.put(32'h0001_0000, ~img[0]);
        u_dma.rest();
        check("refused", 128'(full), 128'h1);
        reg_op(1'b1, `PCIINV_CMD_STATUS_OFFSET, 64'h0);
        reg_op(1'b0, `PCIINV_CMD_STATUS_OFFSET, busy_note);
        reg_op(1'b0, 8'h14, 64'hFFFF_FFFF_0000_0000);
        for (i = 0; i < 5000 && busy !== 1'b0; i++) repeat (8) @(posedge clk);
        check("timeout", 128'(busy), 128'h0);
        // a hung pass skips the upload and goes straight to the verdict
        if (busy === 1'b0) begin
            reg_op(1'b0, `PCIINV_CMD_STATUS_OFFSET, idle_note);
            for (i = 0; i < 80; i++) begin
                dma_q.push_back(~img[i]);
                u_dma.get(32'(i));
            end
            dma_q.push_back(128'h0);
            u_dma.get(32'(`PCIINV_FB_WORDS));
        end
        repeat (4) @(posedge clk);
        check("left", 128'(reg_q.size() + dma_q.size()), 128'h0);
        summarize();
    end
endmodule
`default_nettype wire
